// File: src/hbs_pkg.sv
// Purpose: constants for the holding brake sequencer
// Assumes: 40 MHz control clock
// Notes: register offsets are parameter addresses
package hbs_pkg;
	localparam logic [15:0] HBS_RELEASE_DELAY_OFS = 16'h050e;
	localparam logic [15:0] HBS_APPLY_DELAY_OFS = 16'h0510;
	localparam logic [15:0] HBS_RELEASE_DELAY_RST = 16'h0000;
	localparam logic [15:0] HBS_APPLY_DELAY_RST = 16'h0000;
	localparam logic [15:0] HBS_DELAY_MAX_MS = 16'h03e8;
	localparam int HBS_CLK_HZ = 40000000;
	localparam int HBS_TICK_MS = 1;
	localparam int HBS_TICK_CYCLES = HBS_CLK_HZ / 1000 * HBS_TICK_MS;
	localparam logic [15:0] HBS_TICK_LAST = 16'(HBS_TICK_CYCLES - 1);
	localparam logic [1:0] HBS_OUTSEL_ACTIVE = 2'h0;
endpackage : hbs_pkg

// File: src/hbs_ms_timer.sv
// Purpose: millisecond delay timer
// Assumes: start is a one-cycle pulse
// Notes: zero length gives done in the start cycle
module hbs_ms_timer
	import hbs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic abort,
	input wire logic [15:0] length_ms,
	output logic busy,
	output logic done
);
	logic busy_reg, busy_next;
	logic [15:0] tick_reg, tick_next;
	logic [15:0] ms_reg, ms_next;

	always_comb begin
		busy_next = busy_reg;
		tick_next = tick_reg;
		ms_next = ms_reg;
		done = 1'b0;
		if (abort) begin
			busy_next = 1'b0;
		end else if (start) begin
			tick_next = 16'h0000;
			ms_next = length_ms;
			busy_next = (length_ms != 16'h0000);
			done = (length_ms == 16'h0000);
		end else if (busy_reg) begin
			if (tick_reg == HBS_TICK_LAST) begin
				tick_next = 16'h0000;
				ms_next = ms_reg - 16'h0001;
				if (ms_reg == 16'h0001) begin
					busy_next = 1'b0;
					done = 1'b1;
				end
			end else begin
				tick_next = tick_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_reg <= 1'b0;
			tick_reg <= 16'h0000;
			ms_reg <= 16'h0000;
		end else begin
			busy_reg <= busy_next;
			tick_reg <= tick_next;
			ms_reg <= ms_next;
		end
	end

	assign busy = busy_reg;
endmodule : hbs_ms_timer

// File: src/hbs_sequencer.sv
// Purpose: holding brake sequencing around power amplifier enable/disable
// Assumes: amplifier requests and legacy strap come from pins
// Notes: delays in ms, range 0 to 1000
// Behaviour
// - brake command on configured signal output
// - old firmware uses drive-active output directly
// - on enable release brake, hold motion
// - release delay 16-bit ms, 0..1000
// - disable always commands brake engage
// - keep current for apply delay
// - apply delay 16-bit ms, 0..1000
// - power removal skips apply delay
module hbs_sequencer
	import hbs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic amp_enable_req,
	input wire logic power_removal_b,
	input wire logic legacy_firmware,
	input wire logic [1:0] brake_output_select,
	input wire logic reg_write,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_error,
	output logic drive_active_output,
	output logic [2:0] signal_outputs,
	output logic motor_current_on,
	output logic motion_enable
);
	typedef enum logic [1:0] {HBS_OFF, HBS_RELEASING, HBS_RUN, HBS_APPLYING} hbs_state_e;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] sync1_reg, sync2_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= 3'h2;
			sync2_reg <= 3'h2;
		end else begin
			sync1_reg <= {legacy_firmware, power_removal_b, amp_enable_req};
			sync2_reg <= sync1_reg;
		end
	end
	logic enable_s, safe_ok_s, legacy_s;
	assign enable_s = sync2_reg[0];
	assign safe_ok_s = sync2_reg[1];
	assign legacy_s = sync2_reg[2];

	// ----------------------------------------
	// Delay registers
	// ----------------------------------------
	logic [15:0] release_delay_reg, release_delay_next;
	logic [15:0] apply_delay_reg, apply_delay_next;
	logic reg_error_reg, reg_error_next;
	logic [15:0] rdata_reg, rdata_next;

	always_comb begin
		release_delay_next = release_delay_reg;
		apply_delay_next = apply_delay_reg;
		reg_error_next = 1'b0;
		rdata_next = 16'h0000;
		unique case (reg_addr)
			HBS_RELEASE_DELAY_OFS: rdata_next = release_delay_reg;
			HBS_APPLY_DELAY_OFS: rdata_next = apply_delay_reg;
			default: rdata_next = 16'h0000;
		endcase
		if (reg_write) begin
			if (reg_wdata > HBS_DELAY_MAX_MS) begin
				reg_error_next = 1'b1;
			end else if (reg_addr == HBS_RELEASE_DELAY_OFS) begin
				release_delay_next = reg_wdata;
			end else if (reg_addr == HBS_APPLY_DELAY_OFS) begin
				apply_delay_next = reg_wdata;
			end else begin
				reg_error_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			release_delay_reg <= HBS_RELEASE_DELAY_RST;
			apply_delay_reg <= HBS_APPLY_DELAY_RST;
			reg_error_reg <= 1'b0;
			rdata_reg <= 16'h0000;
		end else begin
			release_delay_reg <= release_delay_next;
			apply_delay_reg <= apply_delay_next;
			reg_error_reg <= reg_error_next;
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;
	assign reg_error = reg_error_reg;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	hbs_state_e state_reg, state_next;
	logic tmr_start, tmr_abort, tmr_done;
	logic [15:0] tmr_len;
	logic release_cmd_reg, release_cmd_next;
	logic current_reg, current_next;
	logic motion_reg, motion_next;

	hbs_ms_timer u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.start(tmr_start),
		.abort(tmr_abort),
		.length_ms(tmr_len),
		.busy(),
		.done(tmr_done)
	);

	always_comb begin
		state_next = state_reg;
		tmr_start = 1'b0;
		tmr_abort = 1'b0;
		tmr_len = release_delay_reg;
		release_cmd_next = release_cmd_reg;
		current_next = current_reg;
		motion_next = 1'b0;
		unique case (state_reg)
			HBS_OFF: begin
				current_next = 1'b0;
				release_cmd_next = 1'b0;
				if (enable_s && safe_ok_s) begin
					release_cmd_next = 1'b1;
					current_next = 1'b1;
					tmr_start = 1'b1;
					state_next = tmr_done ? HBS_RUN : HBS_RELEASING;
					motion_next = tmr_done;
				end
			end
			HBS_RELEASING: begin
				if (!safe_ok_s) begin
					tmr_abort = 1'b1;
					release_cmd_next = 1'b0;
					current_next = 1'b0;
					state_next = HBS_OFF;
				end else if (!enable_s) begin
					// Restart the timer with the apply delay; zero drops current at once
					release_cmd_next = 1'b0;
					tmr_len = apply_delay_reg;
					tmr_start = 1'b1;
					current_next = !tmr_done;
					state_next = tmr_done ? HBS_OFF : HBS_APPLYING;
				end else if (tmr_done) begin
					motion_next = 1'b1;
					state_next = HBS_RUN;
				end
			end
			HBS_RUN: begin
				motion_next = 1'b1;
				if (!safe_ok_s) begin
					release_cmd_next = 1'b0;
					current_next = 1'b0;
					motion_next = 1'b0;
					state_next = HBS_OFF;
				end else if (!enable_s) begin
					release_cmd_next = 1'b0;
					motion_next = 1'b0;
					tmr_len = apply_delay_reg;
					tmr_start = 1'b1;
					current_next = !tmr_done;
					state_next = tmr_done ? HBS_OFF : HBS_APPLYING;
				end
			end
			HBS_APPLYING: begin
				tmr_len = apply_delay_reg;
				if (!safe_ok_s) begin
					tmr_abort = 1'b1;
					current_next = 1'b0;
					state_next = HBS_OFF;
				end else if (tmr_done) begin
					current_next = 1'b0;
					state_next = HBS_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= HBS_OFF;
			release_cmd_reg <= 1'b0;
			current_reg <= 1'b0;
			motion_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			release_cmd_reg <= release_cmd_next;
			current_reg <= current_next;
			motion_reg <= motion_next;
		end
	end

	// ----------------------------------------
	// Output routing
	// ----------------------------------------
	logic drive_active_reg, drive_active_next;
	logic [2:0] outs_reg, outs_next;
	// Route next values so the brake output never lags the motion enable
	always_comb begin
		drive_active_next = release_cmd_next;
		outs_next = 3'h0;
		if (!legacy_s) begin
			for (int i = 0; i < 3; i++) begin
				if (brake_output_select == 2'(i + 1)) begin
					outs_next[i] = release_cmd_next;
				end
			end
			if (brake_output_select != HBS_OUTSEL_ACTIVE) begin
				drive_active_next = current_next;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_active_reg <= 1'b0;
			outs_reg <= 3'h0;
		end else begin
			drive_active_reg <= drive_active_next;
			outs_reg <= outs_next;
		end
	end
	assign drive_active_output = drive_active_reg;
	assign signal_outputs = outs_reg;
	assign motor_current_on = current_reg;
	assign motion_enable = motion_reg;
endmodule : hbs_sequencer

// File: sim/hbs_sequencer_checker.sv
// Purpose: port assertions for the holding brake sequencer
// Assumes: routing and legacy pins change only while idle
// Notes: bound to every sequencer instance
module hbs_sequencer_checker
	import hbs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic amp_enable_req,
	input wire logic power_removal_b,
	input wire logic legacy_firmware,
	input wire logic [1:0] brake_output_select,
	input wire logic reg_write,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_error,
	input wire logic drive_active_output,
	input wire logic [2:0] signal_outputs,
	input wire logic motor_current_on,
	input wire logic motion_enable
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic cmd;
	logic [15:0] rel_reg;
	assign cmd = (legacy_firmware || brake_output_select == 2'h0) ? drive_active_output :
		signal_outputs[brake_output_select - 2'h1];
	// Mirror of the accepted release delay
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rel_reg <= 16'h0;
		end else if (reg_write && reg_addr == HBS_RELEASE_DELAY_OFS &&
			reg_wdata <= HBS_DELAY_MAX_MS) begin
			rel_reg <= reg_wdata;
		end
	end
	property p_spare;
		(legacy_firmware || brake_output_select == 2'h0) |-> signal_outputs == 3'h0;
	endproperty
	a_spare: assert property (p_spare) else $error("spare output set");
	property p_hold;
		motion_enable |-> motor_current_on && cmd;
	endproperty
	a_hold: assert property (p_hold) else $error("motion without release");
	property p_early;
		$rose(motor_current_on) && rel_reg != 16'h0 |-> (!motion_enable)[*8];
	endproperty
	a_early: assert property (p_early) else $error("motion too early");
	property p_zero;
		$rose(motor_current_on) && rel_reg == 16'h0 |-> motion_enable;
	endproperty
	a_zero: assert property (p_zero) else $error("zero delay added time");
	property p_engage;
		(!amp_enable_req)[*4] |-> !cmd && !motion_enable;
	endproperty
	a_engage: assert property (p_engage) else $error("brake not engaged");
	property p_remove;
		(!power_removal_b)[*4] |-> !motor_current_on && !cmd;
	endproperty
	a_remove: assert property (p_remove) else $error("current kept");
	property p_range;
		reg_write && reg_wdata > HBS_DELAY_MAX_MS |=> reg_error;
	endproperty
	a_range: assert property (p_range) else $error("range not refused");
	property p_read;
		!$past(reg_write) && $past(reg_addr) == HBS_RELEASE_DELAY_OFS |-> reg_rdata == rel_reg;
	endproperty
	a_read: assert property (p_read) else $error("release delay readback");
endmodule : hbs_sequencer_checker

bind hbs_sequencer hbs_sequencer_checker hbs_sequencer_checker_inst (.clk, .rst_b,
	.amp_enable_req, .power_removal_b, .legacy_firmware, .brake_output_select, .reg_write,
	.reg_addr, .reg_wdata, .reg_rdata, .reg_error, .drive_active_output, .signal_outputs,
	.motor_current_on, .motion_enable);

// File: sim/hbs_brake_ctrl_model.sv
// Purpose: behavioural brake controller and brake
// Assumes: rst_b stands for its supply power-on
// Notes: brake_volts 0 none, 2 full, 1 reduced
module hbs_brake_ctrl_model #(
	parameter int REDUCE_CYCLES = 200
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic release_cmd,
	input wire logic reduce_on,
	output logic [1:0] brake_volts,
	output logic led_on
);
	timeunit 1ns;
	timeprecision 1ps;
	int held;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b || !release_cmd) begin
			held <= 0;
			brake_volts <= 2'h0;
			led_on <= 1'b0;
		end else begin
			held <= held + 1;
			led_on <= 1'b1;
			brake_volts <= (reduce_on && held >= REDUCE_CYCLES) ? 2'h1 : 2'h2;
		end
	end
endmodule : hbs_brake_ctrl_model

// File: sim/hbs_sequencer_bench.sv
// Purpose: self-checking bench for the holding brake sequencer
// Assumes: tick of 40000 cycles, run near 80000 cycles
// Notes: model keeps delays as integers
module hbs_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import hbs_pkg::*;
	logic clk = 0, rst_b = 0, amp_enable_req = 0, power_removal_b = 1, legacy_firmware = 0;
	logic reg_write = 0, reg_error, drive_active_output, motor_current_on, motion_enable, cmd;
	logic [1:0] brake_output_select = 2'h0, brake_volts;
	logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata;
	logic [2:0] signal_outputs;
	logic led_on;
	logic [31:0] seed = 32'h91f1;
	int n_fail = 0, checks_done = 0, rel = 0, app = 0, cycles = 0, k;
	hbs_sequencer hbs_sequencer_inst (.clk, .rst_b, .amp_enable_req, .power_removal_b,
		.legacy_firmware, .brake_output_select, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_error, .drive_active_output, .signal_outputs, .motor_current_on, .motion_enable);
	hbs_brake_ctrl_model hbs_brake_ctrl_model_inst (.clk, .rst_b, .release_cmd(cmd),
		.reduce_on(1'b1), .brake_volts, .led_on);
	assign cmd = (legacy_firmware || brake_output_select == 2'h0) ? drive_active_output :
		signal_outputs[brake_output_select - 2'h1];
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task in_rng(input int v, input int lo, input int hi);
		chk({15'h0, v >= lo && v <= hi}, 16'h1);
	endtask : in_rng
	task automatic cnt(ref logic s, input logic v, output int n);
		n = 0;
		while (s !== v && n < 50000) begin
			@(posedge clk);
			#1 n++;
		end
	endtask : cnt
	task wr(input logic [15:0] a, input logic [15:0] d);
		logic ok;
		ok = (a == HBS_RELEASE_DELAY_OFS || a == HBS_APPLY_DELAY_OFS) && d <= HBS_DELAY_MAX_MS;
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		#1 chk({15'h0, reg_error}, {15'h0, !ok});
		if (ok && a == HBS_RELEASE_DELAY_OFS) rel = d;
		if (ok && a == HBS_APPLY_DELAY_OFS) app = d;
		repeat (2) @(posedge clk);
		#1 chk(reg_rdata, a == HBS_RELEASE_DELAY_OFS ? 16'(rel) :
			a == HBS_APPLY_DELAY_OFS ? 16'(app) : 16'h0);
	endtask : wr
	task automatic onoff();
		logic [2:0] so;
		so = (legacy_firmware || brake_output_select == 2'h0) ? 3'h0 :
			3'h1 << (brake_output_select - 2'h1);
		@(posedge clk);
		amp_enable_req <= 1'b1;
		cnt(motion_enable, 1'b1, k);
		in_rng(k, rel * HBS_TICK_CYCLES + 3, rel * HBS_TICK_CYCLES + 5);
		chk({13'h0, signal_outputs}, {13'h0, so});
		chk({15'h0, drive_active_output}, 16'h1);
		chk({14'h0, brake_volts}, (k > 300) ? 16'h1 : 16'h0);
		@(posedge clk);
		amp_enable_req <= 1'b0;
		cnt(cmd, 1'b0, k);
		in_rng(k, 3, 4);
		cnt(motor_current_on, 1'b0, k);
		in_rng(k, app * HBS_TICK_CYCLES - 1, app * HBS_TICK_CYCLES + 2);
	endtask : onoff
	task tally_and_finish();
		if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// Clock, reset, timeout and main sequence
	// ----------------------------------------
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		#1 chk({9'h0, led_on, brake_volts, signal_outputs, drive_active_output}, 16'h0);
		wr(HBS_RELEASE_DELAY_OFS, 16'd1001);
		wr(HBS_APPLY_DELAY_OFS, 16'd1001);
		wr(16'h0512, 16'h5);
		wr(HBS_RELEASE_DELAY_OFS, 16'(xs() % 1001));
		wr(HBS_APPLY_DELAY_OFS, HBS_DELAY_MAX_MS);
		wr(HBS_RELEASE_DELAY_OFS, 16'h0);
		wr(HBS_APPLY_DELAY_OFS, 16'h0);
		for (int i = 0; i < 5; i++) begin
			brake_output_select <= (i == 4) ? 2'h2 : 2'(i);
			legacy_firmware <= (i == 4);
			repeat (4) @(posedge clk);
			onoff();
		end
		legacy_firmware <= 1'b0;
		brake_output_select <= 2'(xs() % 3 + 1);
		wr(HBS_RELEASE_DELAY_OFS, 16'h1);
		wr(HBS_APPLY_DELAY_OFS, 16'h1);
		onoff();
		wr(HBS_RELEASE_DELAY_OFS, 16'h0);
		@(posedge clk);
		amp_enable_req <= 1'b1;
		cnt(motion_enable, 1'b1, k);
		@(posedge clk);
		power_removal_b <= 1'b0;
		cnt(motor_current_on, 1'b0, k);
		in_rng(k, 3, 4);
		chk({15'h0, motion_enable}, 16'h0);
		@(posedge clk);
		#1 chk({13'h0, led_on, brake_volts}, 16'h0);
		tally_and_finish();
	end
endmodule : hbs_sequencer_bench
